/* pkg/sws_defs.svh */
// constants of the repeated-write engine: key codes, taskfile values, status codes, sizes
// assumes nothing; included by bare name from the design files
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH

`define SWS_ACTION_WRITE_SAME 16'h0002
`define SWS_FN_BG_PATTERN 16'h0001
`define SWS_FN_BG_SECTOR 16'h0002
`define SWS_FN_BLK_PATTERN 16'h0101
`define SWS_FN_BLK_SECTOR 16'h0102
`define SWS_FN_BLOCKING_BIT 8
`define SWS_FN_SECTOR_BIT 1

`define SWS_TF_STATUS_OK 8'h50
`define SWS_TF_STATUS_ERR 8'h51
`define SWS_TF_ERROR_OK 8'h00
`define SWS_TF_ERROR_ABRT 8'h04
`define SWS_TF_XFER_LSB 8'h01
`define SWS_TF_XFER_MSB 8'h00

`define SWS_EXT_DONE 16'h0000
`define SWS_EXT_RUNNING 16'hFFFF
`define SWS_EXT_BG_HOSTCMD 16'h0008
`define SWS_EXT_BG_MEDIA 16'h0009
`define SWS_EXT_BLK_MEDIA 16'h0017
`define SWS_EXT_BAD_KEY 16'h0001
`define SWS_EXT_RANGE 16'h0002

`define SWS_SECTOR_WORDS 128
`define SWS_FIFO_DEPTH 4

`endif

/* pkg/sws_pkg.sv */
// types shared by the repeated-write engine
// assumes the constants header is compiled alongside
package sws_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_FETCH = 3'b010,
      ST_LOAD = 3'b011,
      ST_PUSH = 3'b100
   } state_t;

endpackage : sws_pkg

/* logic/word_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset; depth a power of two
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("word_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic room_q, room_d, empty_q, empty_d;
   logic push, pop;

   assign in_ready = room_q;
   assign out_valid = ~empty_q;
   assign out_data = mem_q[rp_q];

   always_comb begin
      push = in_valid & room_q;
      pop = out_ready & ~empty_q;
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      room_d = (cnt_d != (AW + 1)'(DEPTH));
      empty_d = (cnt_d == '0);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         room_q <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         room_q <= room_d;
         empty_q <= empty_d;
      end
      if (push)
         mem_q[wp_q] <= in_data;
   end
endmodule : word_fifo

/* logic/sector_ram.sv */
// one-sector buffer, single write port, registered read port
// assumes one clock; contents undefined after reset
`timescale 1ns/1ps
module sector_ram #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 128
) (
   // clock
   input wire logic mclk,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port, data one cycle after address
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   initial begin
      if (DEPTH < 2)
         $error("sector_ram depth must be at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge mclk) begin
      if (wr_en)
         mem_q[wr_addr] <= wr_data;
      rd_data <= mem_q[rd_addr];
   end
endmodule : sector_ram

/* logic/write_same_engine.sv */
// repeated-write engine: takes a decoded key sector, checks the range,
// buffers one host sector if needed and streams sectors to the media port
// assumes key fields arrive decoded on the same clock; media port and host
// command signals are same-clock logic, so nothing here is synchronised
`timescale 1ns/1ps
`include "sws_defs.svh"
module write_same_engine #(
   parameter int LBA_W = 64,
   parameter int DATA_W = 32,
   parameter int SECTOR_WORDS = `SWS_SECTOR_WORDS,
   parameter int FIFO_DEPTH = `SWS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // decoded key sector, cmd_start one-cycle pulse
   input wire logic cmd_start,
   input wire logic [15:0] action_code,
   input wire logic [15:0] function_code,
   input wire logic [LBA_W-1:0] start_lba,
   input wire logic [LBA_W-1:0] sector_count,
   input wire logic [31:0] pattern,
   // other host activity
   input wire logic new_cmd,
   input wire logic new_cmd_is_status,
   input wire logic host_user_write,
   input wire logic capacity_change,
   // drive geometry and retained flag
   input wire logic [LBA_W-1:0] last_user_lba,
   input wire logic seg_init_nv,
   // sector data from host
   input wire logic data_in_valid,
   output logic data_in_ready,
   input wire logic [DATA_W-1:0] data_in,
   // media write port
   output logic media_valid,
   input wire logic media_ready,
   output logic [LBA_W-1:0] media_lba,
   output logic [DATA_W-1:0] media_data,
   output logic media_last,
   input wire logic media_fatal,
   // taskfile result, tf_valid one-cycle pulse
   output logic tf_valid,
   output logic [7:0] tf_error,
   output logic [7:0] tf_status,
   output logic [7:0] tf_sector_count,
   output logic [7:0] tf_sector_number,
   output logic [7:0] tf_cyl_low,
   output logic [7:0] tf_cyl_high,
   // status
   output logic data_request,
   output logic busy,
   output logic [15:0] ext_status,
   output logic [LBA_W-1:0] current_lba,
   output logic seg_init
);
   localparam int WA = $clog2(SECTOR_WORDS);
   initial begin
      if (DATA_W != 32 || LBA_W < 2 || SECTOR_WORDS < 2)
         $error("write_same_engine needs 32-bit data and widths of at least 2");
   end

   // ----------------------------------------------------------------
   // key decode helpers
   // ----------------------------------------------------------------
   function automatic logic fn_known(input logic [15:0] fn);
      return fn == `SWS_FN_BG_PATTERN || fn == `SWS_FN_BG_SECTOR ||
             fn == `SWS_FN_BLK_PATTERN || fn == `SWS_FN_BLK_SECTOR;
   endfunction : fn_known

   // ----------------------------------------------------------------
   // data path buffers
   // ----------------------------------------------------------------
   logic fifo_out_valid, fifo_out_ready, fifo_in_ready;
   logic [DATA_W-1:0] fifo_out_data, ram_rd_data;
   logic [WA-1:0] ram_rd_addr;

   word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_valid(data_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(data_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sws_pkg::state_t st_q, st_d;
   logic [LBA_W-1:0] lba_q, lba_d, end_q, end_d;
   logic [WA-1:0] widx_q, widx_d, ridx_q, ridx_d;
   logic [31:0] pat_q, pat_d;
   logic blocking_q, blocking_d, sector_q, sector_d, full_q, full_d;
   logic [15:0] ext_q, ext_d;
   logic [7:0] tfe_q, tfe_d, tfs_q, tfs_d, tfsc_q, tfsc_d, tfsn_q, tfsn_d;
   logic [7:0] tfcl_q, tfcl_d, tfch_q, tfch_d;
   logic tfv_q, tfv_d, mv_q, mv_d, mlast_q, mlast_d;
   logic [DATA_W-1:0] md_q, md_d;
   logic seg_q, seg_d, nv_pend_q, dreq_q, dreq_d, busy_q, busy_d;
   logic range_bad, interrupt, ram_wr;

   assign ram_rd_addr = widx_q;
   assign fifo_out_ready = (st_q == sws_pkg::ST_RECV);
   assign ram_wr = fifo_out_valid & fifo_out_ready;

   sector_ram #(.WIDTH(DATA_W), .DEPTH(SECTOR_WORDS)) u_ram (
      .mclk(mclk),
      .wr_en(ram_wr),
      .wr_addr(ridx_q),
      .wr_data(fifo_out_data),
      .rd_addr(ram_rd_addr),
      .rd_data(ram_rd_data)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      lba_d = lba_q;
      end_d = end_q;
      widx_d = widx_q;
      ridx_d = ridx_q;
      pat_d = pat_q;
      blocking_d = blocking_q;
      sector_d = sector_q;
      full_d = full_q;
      ext_d = ext_q;
      tfv_d = 1'b0;
      tfe_d = tfe_q;
      tfs_d = tfs_q;
      tfsc_d = tfsc_q;
      tfsn_d = tfsn_q;
      tfcl_d = tfcl_q;
      tfch_d = tfch_q;
      mv_d = mv_q;
      mlast_d = mlast_q;
      md_d = md_q;
      seg_d = seg_q;
      dreq_d = dreq_q;
      busy_d = busy_q;
      // start past the end, or the last addressed sector past the end
      range_bad = (start_lba > last_user_lba) ||
                  (sector_count != '0 &&
                   (sector_count - 1'b1) > (last_user_lba - start_lba));
      // only a background fill can be cut short by the host
      interrupt = new_cmd & ~new_cmd_is_status & ~blocking_q;

      case (st_q)
         sws_pkg::ST_IDLE: begin
            if (cmd_start) begin
               tfv_d = 1'b1;
               if (action_code != `SWS_ACTION_WRITE_SAME ||
                   !fn_known(function_code) || range_bad) begin
                  ext_d = range_bad && action_code == `SWS_ACTION_WRITE_SAME
                          && fn_known(function_code) ? `SWS_EXT_RANGE : `SWS_EXT_BAD_KEY;
                  tfe_d = `SWS_TF_ERROR_ABRT;
                  tfs_d = `SWS_TF_STATUS_ERR;
                  tfsc_d = ext_d[7:0];
                  tfsn_d = ext_d[15:8];
               end else begin
                  blocking_d = function_code[`SWS_FN_BLOCKING_BIT];
                  sector_d = function_code[`SWS_FN_SECTOR_BIT];
                  pat_d = pattern;
                  lba_d = start_lba;
                  end_d = (sector_count == '0) ? last_user_lba
                          : start_lba + sector_count - 1'b1;
                  full_d = (start_lba == '0) && (sector_count == '0 ||
                           start_lba + sector_count - 1'b1 == last_user_lba);
                  ext_d = `SWS_EXT_RUNNING;
                  busy_d = 1'b1;
                  widx_d = '0;
                  ridx_d = '0;
                  tfe_d = `SWS_TF_ERROR_OK;
                  tfs_d = `SWS_TF_STATUS_OK;
                  tfcl_d = `SWS_TF_XFER_LSB;
                  tfch_d = `SWS_TF_XFER_MSB;
                  // blocking pattern fill holds its reply until the end
                  tfv_d = ~function_code[`SWS_FN_BLOCKING_BIT] |
                          function_code[`SWS_FN_SECTOR_BIT];
                  if (function_code[`SWS_FN_SECTOR_BIT]) begin
                     dreq_d = 1'b1;
                     st_d = sws_pkg::ST_RECV;
                  end else begin
                     st_d = sws_pkg::ST_FETCH;
                  end
               end
            end
         end
         sws_pkg::ST_RECV: begin
            if (ram_wr) begin
               ridx_d = ridx_q + 1'b1;
               if (ridx_q == WA'(SECTOR_WORDS - 1)) begin
                  dreq_d = 1'b0;
                  st_d = sws_pkg::ST_FETCH;
                  // background: completion once the data is in
                  tfv_d = ~blocking_q;
               end
            end
         end
         sws_pkg::ST_FETCH: st_d = sws_pkg::ST_LOAD;
         sws_pkg::ST_LOAD: begin
            md_d = sector_q ? ram_rd_data : pat_q;
            mlast_d = (widx_q == WA'(SECTOR_WORDS - 1));
            mv_d = 1'b1;
            st_d = sws_pkg::ST_PUSH;
         end
         sws_pkg::ST_PUSH: begin
            if (mv_q && media_ready) begin
               mv_d = 1'b0;
               // the fill itself writes user sectors; a complete fill sets it again below
               seg_d = 1'b0;
               widx_d = widx_q + 1'b1;
               st_d = sws_pkg::ST_FETCH;
               if (mlast_q) begin
                  widx_d = '0;
                  lba_d = lba_q + 1'b1;
                  if (lba_q == end_q) begin
                     st_d = sws_pkg::ST_IDLE;
                     busy_d = 1'b0;
                     ext_d = `SWS_EXT_DONE;
                     seg_d = full_q;
                     if (blocking_q) begin
                        tfv_d = 1'b1;
                        tfe_d = `SWS_TF_ERROR_OK;
                        tfs_d = `SWS_TF_STATUS_OK;
                     end
                  end
               end
            end
         end
         default: st_d = sws_pkg::ST_IDLE;
      endcase

      // early ends of a running fill take priority over progress
      if (busy_q && (interrupt || media_fatal)) begin
         st_d = sws_pkg::ST_IDLE;
         busy_d = 1'b0;
         mv_d = 1'b0;
         dreq_d = 1'b0;
         if (st_q != sws_pkg::ST_RECV)
            seg_d = 1'b0;
         if (media_fatal && blocking_q) begin
            ext_d = `SWS_EXT_BLK_MEDIA;
            tfv_d = 1'b1;
            tfe_d = `SWS_TF_ERROR_ABRT;
            tfs_d = `SWS_TF_STATUS_ERR;
            tfsc_d = ext_d[7:0];
            tfsn_d = ext_d[15:8];
         end else begin
            ext_d = media_fatal ? `SWS_EXT_BG_MEDIA : `SWS_EXT_BG_HOSTCMD;
         end
      end

      // outside writes and capacity changes win over a completing fill
      if (host_user_write || capacity_change)
         seg_d = 1'b0;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      // working copies of the key are loaded on acceptance, so need no reset
      end_q <= end_d;
      widx_q <= widx_d;
      ridx_q <= ridx_d;
      pat_q <= pat_d;
      sector_q <= sector_d;
      full_q <= full_d;
      if (reset) begin
         st_q <= sws_pkg::ST_IDLE;
         lba_q <= '0;
         blocking_q <= 1'b0;
         ext_q <= `SWS_EXT_DONE;
         tfv_q <= 1'b0;
         tfe_q <= `SWS_TF_ERROR_OK;
         tfs_q <= `SWS_TF_STATUS_OK;
         tfsc_q <= 8'h00;
         tfsn_q <= 8'h00;
         tfcl_q <= 8'h00;
         tfch_q <= 8'h00;
         mv_q <= 1'b0;
         mlast_q <= 1'b0;
         md_q <= '0;
         seg_q <= 1'b0;
         nv_pend_q <= 1'b1;
         dreq_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         lba_q <= lba_d;
         blocking_q <= blocking_d;
         ext_q <= ext_d;
         tfv_q <= tfv_d;
         tfe_q <= tfe_d;
         tfs_q <= tfs_d;
         tfsc_q <= tfsc_d;
         tfsn_q <= tfsn_d;
         tfcl_q <= tfcl_d;
         tfch_q <= tfch_d;
         mv_q <= mv_d;
         mlast_q <= mlast_d;
         md_q <= md_d;
         // retained flag reloaded from storage on the first edge after reset
         seg_q <= nv_pend_q ? seg_init_nv : seg_d;
         nv_pend_q <= 1'b0;
         dreq_q <= dreq_d;
         busy_q <= busy_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   // ready is the buffer's own room flop, so a word is taken exactly when shown ready
   assign data_in_ready = fifo_in_ready;
   assign media_valid = mv_q;
   assign media_lba = lba_q;
   assign media_data = md_q;
   assign media_last = mlast_q;
   assign tf_valid = tfv_q;
   assign tf_error = tfe_q;
   assign tf_status = tfs_q;
   assign tf_sector_count = tfsc_q;
   assign tf_sector_number = tfsn_q;
   assign tf_cyl_low = tfcl_q;
   assign tf_cyl_high = tfch_q;
   assign data_request = dreq_q;
   assign busy = busy_q;
   assign ext_status = ext_q;
   assign current_lba = lba_q;
   assign seg_init = seg_q;
   // reassignment is the media side's business; on the media side only media_fatal ends a fill
endmodule : write_same_engine

/* sim/ws_chk_chk.sv */
// assertions on the ports of the repeated-write engine
// assumes one clock and a synchronous active-high reset; bound by the bench
`timescale 1ns/1ps
`include "sws_defs.svh"
module ws_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // key and host activity
   input wire logic cmd_start,
   input wire logic [15:0] action_code,
   input wire logic [15:0] function_code,
   input wire logic [63:0] start_lba,
   input wire logic [63:0] sector_count,
   input wire logic [31:0] pattern,
   input wire logic new_cmd,
   input wire logic new_cmd_is_status,
   input wire logic host_user_write,
   input wire logic capacity_change,
   input wire logic [63:0] last_user_lba,
   // media and results
   input wire logic media_valid,
   input wire logic media_ready,
   input wire logic [63:0] media_lba,
   input wire logic [31:0] media_data,
   input wire logic media_fatal,
   input wire logic tf_valid,
   input wire logic [7:0] tf_error,
   input wire logic [7:0] tf_status,
   input wire logic [7:0] tf_sector_count,
   input wire logic [7:0] tf_sector_number,
   input wire logic [7:0] tf_cyl_low,
   input wire logic [7:0] tf_cyl_high,
   input wire logic busy,
   input wire logic [15:0] ext_status,
   input wire logic seg_init
);
   logic key_ok, rng_ok, take, bg_q, bg_d, pm_q, pm_d, seen_q, seen_d;
   logic [31:0] pv_q, pv_d;
   logic [63:0] lst_q, lst_d;
   always_comb begin
      key_ok = action_code == 16'h0002 && (function_code == 16'h0001
         || function_code == 16'h0002 || function_code == 16'h0101 || function_code == 16'h0102);
      rng_ok = start_lba <= last_user_lba
         && (sector_count == 64'h0 || start_lba + sector_count - 64'h1 <= last_user_lba);
      take = cmd_start && !busy;
      bg_d = take ? !function_code[8] : bg_q;
      pm_d = take ? !function_code[1] : pm_q;
      pv_d = take ? pattern : pv_q;
      seen_d = busy && (seen_q || (media_valid && media_ready));
      lst_d = (media_valid && media_ready) ? media_lba : lst_q;
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         bg_q <= 1'h0;
         pm_q <= 1'h0;
         seen_q <= 1'h0;
      end else begin
         bg_q <= bg_d;
         pm_q <= pm_d;
         seen_q <= seen_d;
      end
      pv_q <= pv_d;
      lst_q <= lst_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_bg_take;
      take && key_ok && rng_ok && !function_code[8];
   endsequence
   sequence s_bg_ack;
      busy && ext_status == 16'hFFFF && tf_valid
         && {tf_cyl_high, tf_cyl_low, tf_status, tf_error} == 32'h00015000;
   endsequence
   property p_bg_start;
      s_bg_take |=> s_bg_ack;
   endproperty
   a_bg_start: assert property (p_bg_start) else $error("bad background accept");
   property p_bad_key;
      take && !key_ok |=> tf_valid && tf_status == 8'h51 && ext_status == 16'h0001 && !busy;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad key accepted");
   property p_range;
      take && key_ok && !rng_ok |=> tf_valid && ext_status == 16'h0002 && !busy ##1 !media_valid;
   endproperty
   a_range: assert property (p_range) else $error("range error missed");
   property p_err_regs;
      tf_valid && tf_status == 8'h51 |-> tf_error == 8'h04
         && {tf_sector_number, tf_sector_count} == ext_status;
   endproperty
   a_err_regs: assert property (p_err_regs) else $error("error outputs wrong");
   property p_abort;
      bg_q && busy && new_cmd && !new_cmd_is_status && !media_fatal
         |=> !busy && ext_status == 16'h0008 && !tf_valid;
   endproperty
   a_abort: assert property (p_abort) else $error("host abort wrong");
   property p_bg_fatal;
      bg_q && busy && media_fatal |=> !busy && ext_status == 16'h0009;
   endproperty
   a_bg_fatal: assert property (p_bg_fatal) else $error("background fatal wrong");
   property p_blk_fatal;
      !bg_q && busy && media_fatal |-> ##[1:3] tf_valid && tf_status == 8'h51
         && ext_status == 16'h0017;
   endproperty
   a_blk_fatal: assert property (p_blk_fatal) else $error("blocking fatal wrong");
   property p_ascend;
      media_valid && seen_q |-> media_lba == lst_q || media_lba == lst_q + 64'h1;
   endproperty
   a_ascend: assert property (p_ascend) else $error("address order wrong");
   property p_pattern;
      media_valid && busy && pm_q |-> media_data == pv_q;
   endproperty
   a_pattern: assert property (p_pattern) else $error("pattern word wrong");
   property p_flag_clr;
      host_user_write || capacity_change |=> !seg_init;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
   property p_blk_quiet;
      !bg_q && pm_q && busy && media_valid |-> !tf_valid;
   endproperty
   a_blk_quiet: assert property (p_blk_quiet) else $error("early completion");
endmodule : ws_chk

/* sim/media_sink.sv */
// media side model: takes sector words, optionally slowly, and can fail
// assumes the engine's clock; the bench sets the expected fill
`timescale 1ns/1ps
module media_sink (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // media port
   input wire logic media_valid,
   output logic media_ready,
   input wire logic [63:0] media_lba,
   input wire logic [31:0] media_data,
   input wire logic media_last,
   output logic media_fatal,
   // bench controls
   input wire logic clr,
   input wire logic slow,
   input wire logic [15:0] fail_at,
   input wire logic pat_mode,
   input wire logic [31:0] pattern,
   input wire logic [63:0] start_lba
);
   int n;
   int bad;
   logic ph = 1'h0;
   logic [6:0] idx;
   assign idx = n[6:0];
   // slow medium accepts only every other cycle
   assign media_ready = media_valid && (!slow || ph);
   always @(posedge mclk) begin
      ph <= !ph;
      media_fatal <= 1'h0;
      if (reset || clr) begin
         n <= 0;
         bad <= 0;
      end else if (media_valid && media_ready) begin
         if (media_lba !== start_lba + 64'(n / 128)) bad <= bad + 1;
         if (media_data !== (pat_mode ? pattern : 32'hC3C30000 | 32'(idx))) bad <= bad + 1;
         if (media_last !== (idx == 7'h7F)) bad <= bad + 1;
         media_fatal <= fail_at != 16'h0 && n + 1 == int'(fail_at);
         n <= n + 1;
      end
   end
endmodule : media_sink

/* sim/testbench.sv */
// self-checking bench for the repeated-write engine with a media model
// assumes engine, buffers, checker and constants are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic cmd_start = 0, new_cmd = 0, new_cmd_is_status = 0, host_user_write = 0;
   logic capacity_change = 0, seg_init_nv = 1, data_in_valid = 0, clr = 0, slow = 0;
   logic pat_mode = 0, media_ready, media_fatal, data_in_ready, media_valid, media_last;
   logic tf_valid, data_request, busy, seg_init;
   logic [15:0] action_code = 0, function_code = 0, fail_at = 0, ext_status;
   logic [63:0] start_lba = 0, sector_count = 0, last_user_lba = 64'h3, media_lba, current_lba;
   logic [31:0] pattern = 32'h5AA5F00F, data_in = 0, media_data;
   logic [7:0] tf_error, tf_status, tf_sector_count, tf_sector_number, tf_cyl_low, tf_cyl_high;
   int mismatches = 0, checked = 0, tf_n = 0;
   write_same_engine dut (.*);
   media_sink sink (.*);
   always #12.5 mclk = !mclk;
   always @(posedge mclk) if (tf_valid === 1'h1) tf_n++;
   task print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task cyc(int k = 1);
      repeat (k) @(posedge mclk);
      #2;
   endtask : cyc
   task issue(logic [15:0] a, f, logic [63:0] s, c);
      action_code = a;
      function_code = f;
      start_lba = s;
      sector_count = c;
      pat_mode = !f[1];
      clr = 1;
      cmd_start = 1;
      cyc();
      clr = 0;
      cmd_start = 0;
   endtask : issue
   task t_reset();
      `CHK("rst", {1'h1, 8'h50, 16'h0}, {seg_init, tf_status, ext_status})
   endtask : t_reset
   task t_clear(logic cap);
      host_user_write = !cap;
      capacity_change = cap;
      cyc();
      host_user_write = 0;
      capacity_change = 0;
      `CHK("clr", 1'h0, seg_init)
   endtask : t_clear
   task t_fill(logic [15:0] f, logic [63:0] s, c, int nsec, logic full);
      int t0;
      t0 = tf_n;
      issue(16'h0002, f, s, c);
      `CHK("ack", f != 16'h0101, tf_valid)
      if (f != 16'h0101) `CHK("ackr", 32'h00015000, {tf_cyl_high, tf_cyl_low, tf_status, tf_error})
      `CHK("cur", s, current_lba)
      if (f[1]) begin
         while (data_request !== 1'h1) cyc();
         for (int k = 0; k < 128; k++) begin
            data_in_valid = 1;
            data_in = 32'hC3C30000 | k;
            while (data_in_ready !== 1'h1) cyc();
            cyc();
         end
         data_in_valid = 0;
         if (!f[8]) begin
            for (int i = 0; i < 20 && tf_valid !== 1'h1; i++) cyc();
            `CHK("bgdone", 10'h142, {tf_status, busy, data_request})
         end
      end
      for (int i = 0; i < 6000 && busy !== 1'h0; i++) cyc();
      cyc(2);
      `CHK("words", nsec * 128, sink.n)
      `CHK("media", 0, sink.bad)
      `CHK("done", {16'h0, 8'h50}, {ext_status, tf_status})
      `CHK("flag", full, seg_init)
      `CHK("tfn", 1 + int'(f[1]), tf_n - t0)
   endtask : t_fill
   task t_abort();
      issue(16'h0002, 16'h0001, 0, 4);
      while (sink.n < 5) cyc();
      new_cmd = 1;
      new_cmd_is_status = 1;
      cyc();
      new_cmd = 0;
      new_cmd_is_status = 0;
      cyc(2);
      `CHK("stat", 1'h1, busy)
      new_cmd = 1;
      cyc();
      new_cmd = 0;
      `CHK("abort", {1'h0, 16'h0008, 1'h0}, {busy, ext_status, seg_init})
   endtask : t_abort
   task t_fatal(logic [15:0] f, code);
      fail_at = 3;
      issue(16'h0002, f, 0, 2);
      for (int i = 0; i < 200 && busy !== 1'h0; i++) cyc();
      cyc(2);
      fail_at = 0;
      `CHK("fatal", {code, f[8] ? 8'h51 : 8'h50}, {ext_status, tf_status})
   endtask : t_fatal
   task t_err(logic [15:0] a, f, logic [63:0] s, c, logic [15:0] code);
      issue(a, f, s, c);
      `CHK("err", {8'h04, 8'h51, code}, {tf_error, tf_status, tf_sector_number, tf_sector_count})
      `CHK("errx", {1'h1, 1'h0, code}, {tf_valid, busy, ext_status})
      cyc(4);
      `CHK("nowr", 0, sink.n)
   endtask : t_err
   initial begin
      cyc(3);
      reset = 0;
      cyc(2);
      t_reset();
      t_clear(1'h0);
      t_fill(16'h0001, 0, 0, 4, 1'h1);
      t_clear(1'h1);
      slow = 1;
      t_fill(16'h0101, 1, 2, 2, 1'h0);
      t_fill(16'h0002, 3, 1, 1, 1'h0);
      slow = 0;
      t_fill(16'h0102, 0, 0, 4, 1'h1);
      t_abort();
      t_fatal(16'h0001, 16'h0009);
      t_fatal(16'h0101, 16'h0017);
      t_err(16'h0003, 16'h0001, 0, 0, 16'h0001);
      t_err(16'h0002, 16'h0003, 0, 0, 16'h0001);
      t_err(16'h0002, 16'h0001, 4, 0, 16'h0002);
      t_err(16'h0002, 16'h0001, 2, 3, 16'h0002);
      print_verdict();
   end
   // the whole run needs well under 20000 cycles
   initial begin
      #500000;
      mismatches++;
      print_verdict();
   end
endmodule : testbench
bind write_same_engine ws_chk chk (.*);
